/* File: rtl/serial_adc_pkg.sv */
// serial_adc_pkg: shared constants and state types for the serial result port.
// assumes: all users refer to items as serial_adc_pkg::name, nothing is imported.
package serial_adc_pkg;

  // ==========================================
  // widths and counts
  localparam int unsigned RESULT_W = 12;
  localparam int unsigned PIN_W = 4;
  localparam logic [3:0] MSB_IDX = 4'hB;
  localparam logic [3:0] LSB_IDX = 4'h0;
  localparam logic [3:0] LSB_COPY_START = 4'h1;
  localparam logic [3:0] LEAD_LAST_FALL = 4'h1;
  localparam logic [3:0] CFG_LAST_BIT = 4'h2;
  localparam logic [3:0] CFG_SAMPLE_BIT = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // ==========================================
  // configuration word fields, first bit received lands in the top field
  localparam int unsigned CFG_W = 3;
  localparam int unsigned CFG_MODE_POS = 2;
  localparam int unsigned CFG_CHAN_POS = 1;
  localparam int unsigned CFG_ORDER_POS = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;

  // ==========================================
  // synchronised pin positions and reset levels (idle: deselected, clock high)
  localparam int unsigned PIN_SEL_N = 3;
  localparam int unsigned PIN_SCLK = 2;
  localparam int unsigned PIN_DIN = 1;
  localparam int unsigned PIN_TWO_CH = 0;
  localparam logic [PIN_W-1:0] PIN_RESET = 4'hC;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_HUNT,
    ST_CONFIG,
    ST_WAIT_NULL,
    ST_MSB,
    ST_LSB,
    ST_ZEROS
  } port_state_e;

endpackage

/* File: rtl/pin_sync_if.sv */
// pin_sync_if: carries raw pin levels to the synchroniser and clean levels back.
// assumes: one synchroniser and one port core share it on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
  logic [serial_adc_pkg::PIN_W-1:0] raw;
  logic [serial_adc_pkg::PIN_W-1:0] clean;

  modport sync_side (input raw, output clean);
  modport core_side (output raw, input clean);
endinterface
`default_nettype wire

/* File: rtl/pin_sync.sv */
// pin_sync: two flip-flop synchroniser for every asynchronous pin of the port.
// assumes: clk_in domain, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  pin_sync_if.sync_side pins
);
  typedef struct packed {
    logic [serial_adc_pkg::PIN_W-1:0] meta;
    logic [serial_adc_pkg::PIN_W-1:0] stable;
  } sync_s;

  sync_s s_q;
  sync_s s_d;

  // the first stage feeds only the second stage
  always_comb begin
    s_d.meta = pins.raw;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_q <= {serial_adc_pkg::PIN_RESET, serial_adc_pkg::PIN_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign pins.clean = s_q.stable;
endmodule
`default_nettype wire

/* File: rtl/serial_adc_port.sv */
// serial_adc_port: serial control and result port of a 12-bit sampling converter.
// assumes: host drives select, shift clock and data in well below clk_in/4;
// the converter core presents its finished code on code_in during the sample window.
//
// Contract
// [RULE1] bits launch on falling shift clock, incoming bits sampled on rising edge
// [RULE2] single-input variant needs no configuration, starts on select falling
// [RULE3] single-input variant enables data out at second clock pulse after select falls
// [RULE4] single-input variant sends one null bit, then the result
// [RULE5] host raises select after each exchange; port then resets fully
// [RULE6] two-channel variant receives configuration first, then transmits; half duplex
// [RULE7] two-channel variant skips leading zeros; first one is the start bit
// [RULE8] three configuration bits follow start bit, set input and order, start conversion
// [RULE9] after configuration all serial input ignored until select toggles
// [RULE10] two-channel variant samples serial input on rising shift clock
// [RULE11] two-channel variant sends one null bit after configuration, then result
// [RULE12] single-input variant sends msb first then lsb first copy
// [RULE13] further clocks after the data send zeros indefinitely
// [RULE14] bias and comparator power down after conversion while clocking continues
// [RULE15] mode bit: 1 channel against ground, 0 channel difference; next bit picks channel
// [RULE16] low select enables the device, high select powers it down
// [RULE17] result word is twelve bits
// [RULE18] input sampling window lasts one and a half shift clock cycles
// [RULE19] order bit one: msb first then zeros; zero: lsb first copy follows
// [RULE20] with data lines tied, line driven low on fourth falling edge after start
// [RULE21] serial output stays high impedance while select is high
// [RULE22] twelve result bits follow the null bit, one per falling edge
`timescale 1ns/1ps
`default_nettype none
module serial_adc_port (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic select_power_down_n_in,
  input wire logic sclk_in,
  input wire logic data_in,
  input wire logic two_channel_in,
  input wire logic [serial_adc_pkg::RESULT_W-1:0] code_in,
  output logic data_out,
  output logic data_oe_out,
  output logic sampling_out,
  output logic converting_out,
  output logic powered_out,
  output logic input_mode_bit_out,
  output logic channel_select_out,
  output logic output_order_bit_out
);

  // ==========================================
  // pin synchronisation
  pin_sync_if pins ();

  assign pins.raw = {select_power_down_n_in, sclk_in, data_in, two_channel_in};

  pin_sync u_pin_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .pins(pins)
  );

  logic sel_n;
  logic sclk;
  logic din;
  logic two_ch_strap;

  assign sel_n = pins.clean[serial_adc_pkg::PIN_SEL_N];
  assign sclk = pins.clean[serial_adc_pkg::PIN_SCLK];
  assign din = pins.clean[serial_adc_pkg::PIN_DIN];
  assign two_ch_strap = pins.clean[serial_adc_pkg::PIN_TWO_CH];

  // ==========================================
  // port state
  typedef struct packed {
    serial_adc_pkg::port_state_e st;
    logic [3:0] cnt;
    logic sclk_prev;
    logic [serial_adc_pkg::RESULT_W-1:0] result;
    logic [serial_adc_pkg::CFG_W-1:0] cfg;
    logic two_ch;
    logic dout;
    logic oe;
    logic sampling;
    logic converting;
    logic powered;
  } port_s;

  port_s s_q;
  port_s s_d;

  logic rise;
  logic fall;
  logic order_msb_only;

  assign rise = sclk && !s_q.sclk_prev; // [RULE1]
  assign fall = !sclk && s_q.sclk_prev; // [RULE1]
  // the single-input part always sends the lsb-first copy
  assign order_msb_only = s_q.two_ch && s_q.cfg[serial_adc_pkg::CFG_ORDER_POS]; // [RULE19]

  always_comb begin
    s_d = s_q;
    s_d.sclk_prev = sclk;
    s_d.powered = !sel_n; // [RULE16]

    if (sel_n) begin
      // deselect wins over everything: back to idle, line released
      s_d.st = serial_adc_pkg::ST_IDLE; // [RULE5]
      s_d.cnt = serial_adc_pkg::CNT_ZERO;
      s_d.cfg = serial_adc_pkg::CFG_RESET;
      s_d.dout = 1'b0;
      s_d.oe = 1'b0; // [RULE21]
      s_d.sampling = 1'b0;
      s_d.converting = 1'b0; // [RULE16]
    end else begin
      unique case (s_q.st)
        serial_adc_pkg::ST_IDLE: begin
          // strap is taken at the start of each exchange only
          s_d.two_ch = two_ch_strap;
          s_d.cnt = serial_adc_pkg::CNT_ZERO;
          if (two_ch_strap) begin
            s_d.st = serial_adc_pkg::ST_HUNT; // [RULE6]
          end else begin
            s_d.st = serial_adc_pkg::ST_LEAD; // [RULE2]
          end
        end

        serial_adc_pkg::ST_LEAD: begin
          if (rise && s_q.cnt == serial_adc_pkg::CNT_ZERO) begin
            s_d.sampling = 1'b1; // [RULE18]
          end
          if (fall) begin
            if (s_q.cnt == serial_adc_pkg::LEAD_LAST_FALL) begin
              // second pulse: drive the null bit and begin conversion
              s_d.oe = 1'b1; // [RULE3]
              s_d.dout = 1'b0; // [RULE4]
              s_d.sampling = 1'b0; // [RULE18]
              s_d.converting = 1'b1;
              s_d.result = code_in; // [RULE17]
              s_d.cnt = serial_adc_pkg::MSB_IDX;
              s_d.st = serial_adc_pkg::ST_MSB;
            end else begin
              s_d.cnt = s_q.cnt + serial_adc_pkg::CNT_ONE;
            end
          end
        end

        serial_adc_pkg::ST_HUNT: begin
          if (rise && din) begin
            s_d.cnt = serial_adc_pkg::CNT_ZERO; // [RULE7]
            s_d.st = serial_adc_pkg::ST_CONFIG;
          end
        end

        serial_adc_pkg::ST_CONFIG: begin
          if (rise) begin
            s_d.cfg = {s_q.cfg[serial_adc_pkg::CFG_W-2:0], din}; // [RULE8] [RULE10]
            if (s_q.cnt == serial_adc_pkg::CFG_SAMPLE_BIT) begin
              s_d.sampling = 1'b1; // [RULE18]
            end
            if (s_q.cnt == serial_adc_pkg::CFG_LAST_BIT) begin
              s_d.st = serial_adc_pkg::ST_WAIT_NULL; // [RULE9]
            end else begin
              s_d.cnt = s_q.cnt + serial_adc_pkg::CNT_ONE;
            end
          end
        end

        serial_adc_pkg::ST_WAIT_NULL: begin
          // fourth falling edge after the start bit takes the shared line
          if (fall) begin
            s_d.oe = 1'b1; // [RULE20]
            s_d.dout = 1'b0; // [RULE11]
            s_d.sampling = 1'b0; // [RULE18]
            s_d.converting = 1'b1; // [RULE8]
            s_d.result = code_in; // [RULE17]
            s_d.cnt = serial_adc_pkg::MSB_IDX;
            s_d.st = serial_adc_pkg::ST_MSB;
          end
        end

        serial_adc_pkg::ST_MSB: begin
          if (fall) begin
            s_d.dout = s_q.result[s_q.cnt]; // [RULE22] [RULE12]
            if (s_q.cnt == serial_adc_pkg::LSB_IDX) begin
              // last bit resolved: bias and comparator may shut off
              s_d.converting = 1'b0; // [RULE14]
              if (order_msb_only) begin
                s_d.st = serial_adc_pkg::ST_ZEROS; // [RULE19]
              end else begin
                s_d.cnt = serial_adc_pkg::LSB_COPY_START;
                s_d.st = serial_adc_pkg::ST_LSB; // [RULE12]
              end
            end else begin
              s_d.cnt = s_q.cnt - serial_adc_pkg::CNT_ONE;
            end
          end
        end

        serial_adc_pkg::ST_LSB: begin
          if (fall) begin
            s_d.dout = s_q.result[s_q.cnt]; // [RULE12] [RULE19]
            if (s_q.cnt == serial_adc_pkg::MSB_IDX) begin
              s_d.st = serial_adc_pkg::ST_ZEROS;
            end else begin
              s_d.cnt = s_q.cnt + serial_adc_pkg::CNT_ONE;
            end
          end
        end

        serial_adc_pkg::ST_ZEROS: begin
          if (fall) begin
            s_d.dout = 1'b0; // [RULE13]
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_q.st <= serial_adc_pkg::ST_IDLE;
      s_q.cnt <= serial_adc_pkg::CNT_ZERO;
      s_q.sclk_prev <= 1'b1;
      s_q.result <= '0;
      s_q.cfg <= serial_adc_pkg::CFG_RESET;
      s_q.two_ch <= 1'b0;
      s_q.dout <= 1'b0;
      s_q.oe <= 1'b0;
      s_q.sampling <= 1'b0;
      s_q.converting <= 1'b0;
      s_q.powered <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs, all straight from state flops
  assign data_out = s_q.dout;
  assign data_oe_out = s_q.oe;
  assign sampling_out = s_q.sampling;
  assign converting_out = s_q.converting;
  assign powered_out = s_q.powered;
  // selection applies in the two-channel variant only
  assign input_mode_bit_out = s_q.cfg[serial_adc_pkg::CFG_MODE_POS]; // [RULE15]
  assign channel_select_out = s_q.cfg[serial_adc_pkg::CFG_CHAN_POS]; // [RULE15]
  assign output_order_bit_out = s_q.cfg[serial_adc_pkg::CFG_ORDER_POS];

endmodule
`default_nettype wire

/* File: sim/serial_adc_port_sva.sv */
// port_chk: timing relations of the serial result port.
// assumes: bound into serial_adc_port; host holds each shift clock phase >= 4 clk.
`timescale 1ns/1ps
`default_nettype none
module port_chk (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic select_power_down_n_in,
  input wire logic sclk_in,
  input wire logic data_out,
  input wire logic data_oe_out,
  input wire logic sampling_out,
  input wire logic converting_out,
  input wire logic powered_out,
  input wire logic input_mode_bit_out,
  input wire logic channel_select_out,
  input wire logic output_order_bit_out
);
  wire logic desel = select_power_down_n_in;
  wire logic cfg_any = input_mode_bit_out | channel_select_out | output_order_bit_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ====
  // assertions: four deselected edges cover the sync delay
  AST_OE_OFF: assert property (desel [*4] |-> !data_oe_out)
    else $error("data line driven while deselected");
  AST_PWR_OFF: assert property (desel [*4] |-> !powered_out && !converting_out)
    else $error("powered while deselected");
  AST_CFG_CLR: assert property (desel [*4] |-> !cfg_any)
    else $error("configuration kept after deselect");
  AST_BIT_ON_FALL: assert property (data_oe_out && $changed(data_out) |-> !$past(sclk_in, 2) && $past(sclk_in, 5))
    else $error("output bit changed off a falling shift clock");
  AST_OE_ON_FALL: assert property ($rose(data_oe_out) |-> !$past(sclk_in, 2) && $past(sclk_in, 5) && !data_out)
    else $error("output enabled off a falling shift clock");
  AST_CONV_START: assert property ($rose(converting_out) |-> data_oe_out && !data_out && !sampling_out)
    else $error("conversion start without null bit");
  AST_SAMPLE_PWR: assert property ($rose(sampling_out) |-> powered_out && !converting_out && !data_oe_out)
    else $error("sample window opened in wrong phase");
  AST_CONV_END: assert property ($fell(converting_out) && powered_out |-> data_oe_out)
    else $error("conversion ended while not sending");
  cover property ($fell(converting_out) && powered_out);
  cover property (output_order_bit_out && $rose(data_oe_out));
  cover property ($rose(sampling_out));
endmodule
bind serial_adc_port port_chk chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .select_power_down_n_in(select_power_down_n_in), .sclk_in(sclk_in), .data_out(data_out),
  .data_oe_out(data_oe_out), .sampling_out(sampling_out), .converting_out(converting_out),
  .powered_out(powered_out), .input_mode_bit_out(input_mode_bit_out),
  .channel_select_out(channel_select_out), .output_order_bit_out(output_order_bit_out));
`default_nettype wire

/* File: sim/host_model.sv */
// host_model: host side of the port, drives select, shift clock and data in.
// assumes: clk_in rising edge; each shift clock phase lasts 6 clk cycles.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_in,
  input wire logic data_out_in,
  input wire logic data_oe_in,
  input wire logic [2:0] cfg_in,
  output logic sel_n_out,
  output logic sclk_out,
  output logic din_out
);
  logic rx[1:40];
  logic oe[1:40];
  logic [2:0] cfg_q;
  initial begin
    sel_n_out = 1'b1;
    sclk_out = 1'b0;
    din_out = 1'b0;
  end
  task automatic half();
    repeat (6) @(posedge clk_in);
  endtask
  // ====
  // one exchange of n clocks; rx and oe keep what was seen at each rise
  task automatic xfer(input logic two, input logic [2:0] cfg, input int lead, input int n);
    @(posedge clk_in) sel_n_out <= 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      if (two && i <= lead + 3)
        din_out <= (i < lead) ? 1'b0 : (i == lead) ? 1'b1 : cfg[lead + 3 - i];
      else
        din_out <= ~din_out; // released line keeps moving so a stale read shows
      half();
      sclk_out <= 1'b1;
      // an undriven line has no pull, so it reads as the inverse to expose a stale read
      rx[i + 1] = data_oe_in ? data_out_in : ~data_out_in;
      oe[i + 1] = data_oe_in;
      cfg_q = cfg_in;
      half();
      sclk_out <= 1'b0;
    end
    @(posedge clk_in) sel_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// tb_top: runs exchanges of both variants and checks the returned bit stream.
// assumes: host_model and the checker bind are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic two = 1'b0;
  logic [serial_adc_pkg::RESULT_W-1:0] code = 12'h801;
  logic sel_n, sclk, din, dout, doe, mode, chan, order;
  logic samp, conv, pwr;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  always #4 clk_in = ~clk_in;
  serial_adc_port dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .select_power_down_n_in(sel_n),
    .sclk_in(sclk), .data_in(din), .two_channel_in(two), .code_in(code), .data_out(dout),
    .data_oe_out(doe), .sampling_out(samp), .converting_out(conv), .powered_out(pwr),
    .input_mode_bit_out(mode), .channel_select_out(chan), .output_order_bit_out(order));
  host_model host_u (.clk_in(clk_in), .data_out_in(dout), .data_oe_in(doe), .cfg_in({mode, chan, order}),
    .sel_n_out(sel_n), .sclk_out(sclk), .din_out(din));
  task automatic results();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %b expected %b", $time, got, exp);
    end
  endtask
  // ====
  // nr is the rise that sees the null bit
  task automatic check_rx(input int nr, input logic [11:0] c, input logic copy);
    logic e;
    for (int r = nr; r <= nr + 24; r++) begin
      e = (r > nr && r <= nr + 12) ? c[nr + 12 - r] : (copy && r > nr + 12 && r <= nr + 23) ? c[r - nr - 12] : 1'b0;
      chk(host_u.rx[r], e);
      chk(host_u.oe[r], 1'b1);
    end
    chk(host_u.oe[nr - 1], 1'b0);
  endtask
  // hang guard, the full run needs about 3600 cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    host_u.xfer(1'b0, 3'h0, 0, 30);
    check_rx(3, code, 1'b1);
    chk(host_u.cfg_q === 3'h0, 1'b1);
    two <= 1'b1;
    code <= 12'hFFF;
    // cut after three result bits: null on rise 6, then ones
    host_u.xfer(1'b1, 3'h2, 1, 9);
    chk(host_u.rx[6], 1'b0);
    for (int r = 7; r <= 9; r++) begin
      chk(host_u.rx[r], 1'b1);
    end
    chk(doe, 1'b0);
    chk({mode, chan, order} === 3'h0, 1'b1);
    chk(pwr | conv | samp, 1'b0);
    for (int c = 0; c < 8; c++) begin
      code <= 12'hA5C ^ {c[2:0], c[2:0], c[2:0], c[2:0]};
      host_u.xfer(1'b1, c[2:0], c % 3, c % 3 + 30);
      check_rx(c % 3 + 5, code, ~c[0]);
      chk(host_u.cfg_q === c[2:0], 1'b1);
    end
    results();
  end
endmodule
`default_nettype wire
